/* inc/dffsr_pkg.sv */
// Constants shared by the edge-triggered storage element with force inputs.
`default_nettype none
package dffsr_pkg;

  // Number of flip-flops each pin passes before logic reads it.
  localparam int SYNC_LEN = 2;

  // Bit positions of the pins inside the synchroniser vector.
  localparam int PIN_COUNT      = 4;
  localparam int BIT_FORCE_HI_N = 0;
  localparam int BIT_FORCE_LO_N = 1;
  localparam int BIT_EDGE_CLOCK = 2;
  localparam int BIT_DATA       = 3;

  // Synchroniser reset: force inputs idle high and the clock idle high, so that
  // a clock pin held high across reset release does not look like a rising edge.
  localparam logic [PIN_COUNT-1:0] SYNC_RESET = 4'hF;
  localparam logic                 CLK_PREV_RESET = 1'h1;

  // Stored value after reset.
  localparam logic TRUE_RESET  = 1'h0;
  localparam logic COMPL_RESET = 1'h1;

  // Levels driven while a force input is asserted.
  localparam logic LEVEL_HIGH = 1'h1;
  localparam logic LEVEL_LOW  = 1'h0;

endpackage : dffsr_pkg

`default_nettype wire

/* verilog/dffsr_top.sv */
// Edge-triggered D storage element with active-low force-high and force-low pins.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - Force-high alone gives true high, complement low.
// - Force-low alone gives true low, complement high.
// - Both forces low drive both outputs high.
// - Forces act without clock, overriding clocked loads.
// - Rising edge loads data, complement gets inverse.
// - Complement is inverse except when both forced, and held so until a load or single force.
// - Without forces, state changes only on rising edges.
module dffsr_top
  import dffsr_pkg::*;
(
  input  wire logic I_REF_CLK,
  input  wire logic I_RST,
  input  wire logic I_EDGE_CLOCK,
  input  wire logic I_DATA,
  input  wire logic I_FORCE_HIGH_N,
  input  wire logic I_FORCE_LOW_N,
  output var  logic O_TRUE,
  output var  logic O_COMPL
);

  wire logic [PIN_COUNT-1:0] pin_raw;
  wire logic [PIN_COUNT-1:0] sync_pin;
  logic                      clk_prev;
  logic                      force_high_n;
  logic                      force_low_n;
  logic                      edge_clock;
  logic                      data;
  logic                      rise;

  // Pin levels gathered in synchroniser order.
  assign pin_raw[BIT_FORCE_HI_N] = I_FORCE_HIGH_N;
  assign pin_raw[BIT_FORCE_LO_N] = I_FORCE_LOW_N;
  assign pin_raw[BIT_EDGE_CLOCK] = I_EDGE_CLOCK;
  assign pin_raw[BIT_DATA]       = I_DATA;

  // Every pin is asynchronous to the reference clock; two stages per bit.
  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi = gi + 1) begin : g_sync
      logic meta;
      logic stage;
      always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
          meta  <= SYNC_RESET[gi];
          stage <= SYNC_RESET[gi];
        end else begin
          meta  <= pin_raw[gi];
          stage <= meta;
        end
      end
      assign sync_pin[gi] = stage;
    end
  endgenerate

  assign force_high_n = sync_pin[BIT_FORCE_HI_N];
  assign force_low_n  = sync_pin[BIT_FORCE_LO_N];
  assign edge_clock   = sync_pin[BIT_EDGE_CLOCK];
  assign data         = sync_pin[BIT_DATA];

  // Previous clock level for edge detection; falling edges are never used.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      clk_prev <= CLK_PREV_RESET;
    end else begin
      clk_prev <= edge_clock;
    end
  end

  assign rise = edge_clock & ~clk_prev;

  // True output. Force inputs take priority over any clocked load.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_TRUE <= TRUE_RESET;
    end else if (!force_high_n) begin
      O_TRUE <= LEVEL_HIGH;
    end else if (!force_low_n) begin
      O_TRUE <= LEVEL_LOW;
    end else if (rise) begin
      O_TRUE <= data;
    end
    // Otherwise the value, forced or loaded, is held.
  end

  // Complement output, kept as its own flip-flop so both can read high.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      O_COMPL <= COMPL_RESET;
    end else if (!force_high_n && !force_low_n) begin
      O_COMPL <= LEVEL_HIGH;
    end else if (!force_high_n) begin
      O_COMPL <= LEVEL_LOW;
    end else if (!force_low_n) begin
      O_COMPL <= LEVEL_HIGH;
    end else if (rise) begin
      O_COMPL <= ~data;
    end
  end

  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);

  property p_force_high;
    (!force_high_n && force_low_n) |=> (O_TRUE && !O_COMPL);
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("Force-high did not give true high and complement low.");

  property p_force_low;
    (force_high_n && !force_low_n) |=> (!O_TRUE && O_COMPL);
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("Force-low did not give true low and complement high.");

  property p_force_both;
    (!force_high_n && !force_low_n)[*2] |=> (O_TRUE && O_COMPL);
  endproperty
  a_force_both: assert property (p_force_both)
    else $error("Both forces low did not drive both outputs high.");

  property p_force_beats_edge;
    (rise && force_high_n && !force_low_n && data) |=> !O_TRUE;
  endproperty
  a_force_beats_edge: assert property (p_force_beats_edge)
    else $error("A clock edge overrode an asserted force input.");

  property p_edge_load;
    (rise && force_high_n && force_low_n) |=>
      (O_TRUE == $past(data)) && (O_COMPL == !$past(data));
  endproperty
  a_edge_load: assert property (p_edge_load)
    else $error("Rising edge did not load the data level.");

  property p_complement;
    (force_high_n && force_low_n && rise) ##1 (force_high_n && force_low_n)
      |-> (O_TRUE != O_COMPL);
  endproperty
  a_complement: assert property (p_complement)
    else $error("Complement output is not the inverse of the true output.");

  property p_no_fall_load;
    (force_high_n && force_low_n && clk_prev && !edge_clock) |=>
      ($stable(O_TRUE) && $stable(O_COMPL));
  endproperty
  a_no_fall_load: assert property (p_no_fall_load)
    else $error("State changed on a falling clock edge.");

  property p_hold;
    (force_high_n && force_low_n && !rise)[*3] |=>
      ($stable(O_TRUE) && $stable(O_COMPL));
  endproperty
  a_hold: assert property (p_hold)
    else $error("State changed between rising clock edges.");

  property p_release_hold;
    ($rose(force_high_n) && force_low_n && !rise) |=> O_TRUE;
  endproperty
  a_release_hold: assert property (p_release_hold)
    else $error("Forced high value was lost after release without an edge.");

  property p_single_low_beats;
    (rise && force_high_n && !force_low_n) |=> (!O_TRUE && O_COMPL);
  endproperty
  a_single_low_beats: assert property (p_single_low_beats)
    else $error("A clock edge disturbed the forced low state.");

  property p_high_beats_edge;
    (rise && !force_high_n && force_low_n && !data) |=> (O_TRUE && !O_COMPL);
  endproperty
  a_high_beats_edge: assert property (p_high_beats_edge)
    else $error("A clock edge with low data overrode the forced high state.");

  property p_both_beats_edge;
    (rise && !force_high_n && !force_low_n) |=> (O_TRUE && O_COMPL);
  endproperty
  a_both_beats_edge: assert property (p_both_beats_edge)
    else $error("A clock edge disturbed the both-forced state.");

  property p_compl_single;
    (force_high_n != force_low_n) |=> (O_TRUE != O_COMPL);
  endproperty
  a_compl_single: assert property (p_compl_single)
    else $error("Outputs were equal under a single force input.");

  property p_compl_kept;
    ((force_high_n || force_low_n) && (O_TRUE != O_COMPL)) |=>
      (O_TRUE != O_COMPL);
  endproperty
  a_compl_kept: assert property (p_compl_kept)
    else $error("Complement stopped being the inverse without both forces low.");

  property p_change_cause;
    ($changed(O_TRUE) || $changed(O_COMPL)) |->
      ($past(rise) || !$past(force_high_n) || !$past(force_low_n) || $past(I_RST));
  endproperty
  a_change_cause: assert property (p_change_cause)
    else $error("Outputs changed without a rising edge or a force input.");

  property p_release_low_hold;
    ($rose(force_low_n) && $past(force_high_n) && force_high_n && !rise) |=>
      (!O_TRUE && O_COMPL);
  endproperty
  a_release_low_hold: assert property (p_release_low_hold)
    else $error("Forced low value was lost after release without an edge.");

  property p_both_release;
    ($rose(force_high_n) && $rose(force_low_n) && !rise) |=> (O_TRUE && O_COMPL);
  endproperty
  a_both_release: assert property (p_both_release)
    else $error("Both-high state was lost after joint release without an edge.");

  property p_edge_track;
    !$past(I_RST) |-> (clk_prev == $past(edge_clock));
  endproperty
  a_edge_track: assert property (p_edge_track)
    else $error("Edge detector does not follow the synchronised clock level.");

endmodule : dffsr_top

`default_nettype wire

/* bench/dffsr_pins.sv */
// Pin driver standing in for the logic around the storage element.
`timescale 1ns/10ps
`default_nettype none
module dffsr_pins (
  input  wire logic i_clk,
  output var  logic o_edge_clock,
  output var  logic o_data,
  output var  logic o_force_high_n,
  output var  logic o_force_low_n
);
  initial begin
    {o_edge_clock, o_data, o_force_high_n, o_force_low_n} = 4'h3;
  end
  // Pins move together just after a reference edge, as whole levels.
  task automatic drive(input logic [3:0] v);
    @(posedge i_clk);
    #1 {o_edge_clock, o_data, o_force_high_n, o_force_low_n} = v;
  endtask : drive
endmodule : dffsr_pins
`default_nettype wire

/* bench/dffsr_top_tb.sv */
// Self-checking bench for the storage element with force pins.
`timescale 1ns/10ps
`default_nettype none
module dffsr_top_tb;
  logic ref_clk = 1'h0;
  logic rst     = 1'h1;
  logic edge_clock, data, fh_n, fl_n, o_true, o_compl;
  int   n_errors    = 0;
  int   checks_done = 0;
  always #5 ref_clk = ~ref_clk;
  dffsr_pins pins (.i_clk(ref_clk), .o_edge_clock(edge_clock), .o_data(data),
    .o_force_high_n(fh_n), .o_force_low_n(fl_n));
  dffsr_top uut (.I_REF_CLK(ref_clk), .I_RST(rst), .I_EDGE_CLOCK(edge_clock),
    .I_DATA(data), .I_FORCE_HIGH_N(fh_n), .I_FORCE_LOW_N(fl_n),
    .O_TRUE(o_true), .O_COMPL(o_compl));
  // Pins are {clock, data, force_high_n, force_low_n}; outputs {true, compl}.
  task automatic step(input logic [3:0] v, input logic [1:0] exp);
    pins.drive(v);
    repeat (5) @(posedge ref_clk);
    #1 checks_done++;
    if ({o_true, o_compl} !== exp) begin
      n_errors++;
      $display("unexpected at %0t: outputs %b, want %b", $time, {o_true, o_compl}, exp);
    end
  endtask : step
  task automatic t_force();
    step(4'h3, 2'h1);
    step(4'h1, 2'h2);
    step(4'h3, 2'h2);
    step(4'h2, 2'h1);
    step(4'h3, 2'h1);
    $display("test force done");
  endtask : t_force
  task automatic t_both();
    step(4'h0, 2'h3);
    step(4'h8, 2'h3);
    step(4'h3, 2'h3);
    $display("test both done");
  endtask : t_both
  task automatic t_load();
    step(4'h7, 2'h3);
    step(4'hF, 2'h2);
    step(4'h3, 2'h2);
    step(4'hB, 2'h1);
    step(4'h7, 2'h1);
    $display("test load done");
  endtask : t_load
  task automatic t_override();
    step(4'h6, 2'h1);
    step(4'hE, 2'h1);
    step(4'hB, 2'h1);
    step(4'h1, 2'h2);
    step(4'h9, 2'h2);
    $display("test override done");
  endtask : t_override
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'h0;
    t_force();
    t_both();
    t_load();
    t_override();
    report_and_stop();
  end
endmodule : dffsr_top_tb
`default_nettype wire
